/* File: core/t1rec_pkg.sv */
`default_nettype none
package t1rec_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_LINE_HIGH = 8'h23;
   localparam logic [7:0] ADDR_LINE_LOW  = 8'h24;
   localparam logic [7:0] ADDR_NIBBLES   = 8'h25;
   localparam logic [7:0] ADDR_PATH_LOW  = 8'h26;
   localparam logic [7:0] ADDR_SYNC_LOW  = 8'h27;
   localparam logic [7:0] READ_UNMAPPED  = 8'h00;
   // Counter widths
   localparam int LINE_WIDTH = 16;
   localparam int PATH_WIDTH = 12;
   localparam int SYNC_WIDTH = 12;
   // Zero run lengths
   localparam logic [4:0] ZERO_RUN_B8ZS  = 5'h08;
   localparam logic [4:0] ZERO_RUN_PLAIN = 5'h10;
   // One second timing
   localparam int unsigned CLK_KHZ          = 25000;
   localparam int unsigned SEC_SHORT_MS     = 999;
   localparam int unsigned SEC_LONG_MS      = 1002;
   localparam int unsigned SEC_SHORT_CYCLES = SEC_SHORT_MS * CLK_KHZ;
   localparam int unsigned SEC_LONG_CYCLES  = SEC_LONG_MS * CLK_KHZ;
   localparam logic [31:0] SEC_CNT_RESET    = 32'h0;
   localparam logic [31:0] SEC_CNT_STEP     = 32'h1;
   // Position in the three second pattern
   typedef enum logic [1:0] {
      PH_FIRST,
      PH_SECOND,
      PH_LONG
   } t1rec_phase_t;
endpackage
`default_nettype wire

/* File: core/t1rec_sat_counter.sv */
`default_nettype none
module t1rec_sat_counter #(
   parameter int WIDTH = 12
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst,
   // Control
   input  wire logic             count_event,
   input  wire logic             restart,
   // Count
   output logic [WIDTH-1:0]      count
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
   } t1rec_cnt_state_t;

   t1rec_cnt_state_t st;
   t1rec_cnt_state_t next_st;

   always_comb begin
      next_st = st;
      if (restart) begin
         next_st.count = {{(WIDTH-1){1'b0}}, count_event};
      end else if (count_event && st.count != {WIDTH{1'b1}}) begin
         next_st.count = st.count + 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign count = st.count;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   property p_saturate;
      !restart && st.count == {WIDTH{1'b1}} |=> st.count == {WIDTH{1'b1}};
   endproperty
   a_saturate: assert property (p_saturate)
      else $error("counter left its maximum");

   property p_restart;
      restart |=> st.count == {{(WIDTH-1){1'b0}}, $past(count_event)};
   endproperty
   a_restart: assert property (p_restart)
      else $error("counter did not restart");
endmodule
`default_nettype wire

/* File: core/t1rec_error_counters.sv */
`default_nettype none
// What this block does
// - 16-bit line count, high then low byte
// - Excess zeros add 16 or 8 zero runs
// - Valid B8ZS code words not counted
// - Line counter runs during sync loss
// - ESF path counter counts CRC6 errors
// - D4 path counts Ft, optionally Fs
// - Path counter frozen during sync loss
// - Path high nibble low at 25h, low 26h
// - Select one counts out-of-sync multiframes
// - Select zero counts Ft/FPS errors, in sync
// - Sync high nibble upper 25h, low 27h
// - Snapshot all counters each second boundary
// - Counters saturate, never wrap
// - Intervals 999, 999, 1002 ms repeating
module t1rec_error_counters #(
   parameter int unsigned SHORT_CYCLES = t1rec_pkg::SEC_SHORT_CYCLES,
   parameter int unsigned LONG_CYCLES  = t1rec_pkg::SEC_LONG_CYCLES
) (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // Configuration
   input  wire logic       receive_b8zs_enable,
   input  wire logic       receive_esf_select,
   input  wire logic       count_excess_zeros_enable,
   input  wire logic       count_fs_errors_enable,
   input  wire logic       out_of_sync_count_select,
   // Line decoder events
   input  wire logic       line_bit_strobe,
   input  wire logic       line_bit_zero,
   input  wire logic       bipolar_violation,
   input  wire logic       b8zs_code_word,
   // Framer events
   input  wire logic       receive_sync_lost,
   input  wire logic       crc6_error,
   input  wire logic       ft_error,
   input  wire logic       fs_error,
   input  wire logic       fps_error,
   input  wire logic       multiframe_boundary,
   // Register read port
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   output logic [7:0]      reg_rdata,
   output logic            reg_rvalid,
   // Status
   output logic            one_second_flag
);
   typedef struct packed {
      logic [31:0]                      sec_cnt;
      t1rec_pkg::t1rec_phase_t          phase;
      logic [4:0]                       zero_run;
      logic                             sec_flag;
      logic [t1rec_pkg::LINE_WIDTH-1:0] snap_line;
      logic [t1rec_pkg::PATH_WIDTH-1:0] snap_path;
      logic [t1rec_pkg::SYNC_WIDTH-1:0] snap_sync;
      logic [7:0]                       rdata;
      logic                             rvalid;
   } t1rec_state_t;

   t1rec_state_t                     st;
   t1rec_state_t                     next_st;
   logic [31:0]                      sec_limit;
   logic                             boundary;
   logic [4:0]                       zero_target;
   logic                             zero_hit;
   logic                             bpv_counted;
   logic                             line_event;
   logic                             path_event;
   logic                             sync_event;
   logic [t1rec_pkg::LINE_WIDTH-1:0] line_acc;
   logic [t1rec_pkg::PATH_WIDTH-1:0] path_acc;
   logic [t1rec_pkg::SYNC_WIDTH-1:0] sync_acc;

   assign sec_limit = (st.phase == t1rec_pkg::PH_LONG) ? 32'(LONG_CYCLES)
                                                       : 32'(SHORT_CYCLES);
   assign boundary = (st.sec_cnt == sec_limit - t1rec_pkg::SEC_CNT_STEP);

   assign zero_target = receive_b8zs_enable ? t1rec_pkg::ZERO_RUN_B8ZS
                                            : t1rec_pkg::ZERO_RUN_PLAIN;
   assign zero_hit = count_excess_zeros_enable && line_bit_strobe &&
                     line_bit_zero && (st.zero_run == zero_target - 5'h01);

   assign bpv_counted = bipolar_violation &&
                        !(receive_b8zs_enable && b8zs_code_word);
   assign line_event = bpv_counted || zero_hit;

   always_comb begin
      path_event = receive_esf_select ? crc6_error
                 : (ft_error || (count_fs_errors_enable && fs_error));
      if (receive_sync_lost) begin
         path_event = 1'b0;
      end
   end

   always_comb begin
      if (out_of_sync_count_select) begin
         sync_event = multiframe_boundary && receive_sync_lost;
      end else begin
         sync_event = !receive_sync_lost &&
                      (receive_esf_select ? fps_error : ft_error);
      end
   end

   t1rec_sat_counter #(
      .WIDTH (t1rec_pkg::LINE_WIDTH)
   ) u_line_counter (
      .core_clk    (core_clk),
      .rst         (rst),
      .count_event (line_event),
      .restart     (boundary),
      .count       (line_acc)
   );

   t1rec_sat_counter #(
      .WIDTH (t1rec_pkg::PATH_WIDTH)
   ) u_path_counter (
      .core_clk    (core_clk),
      .rst         (rst),
      .count_event (path_event),
      .restart     (boundary),
      .count       (path_acc)
   );

   t1rec_sat_counter #(
      .WIDTH (t1rec_pkg::SYNC_WIDTH)
   ) u_sync_counter (
      .core_clk    (core_clk),
      .rst         (rst),
      .count_event (sync_event),
      .restart     (boundary),
      .count       (sync_acc)
   );

   always_comb begin
      next_st = st;
      next_st.sec_flag = boundary;
      next_st.rvalid = reg_rd;
      if (boundary) begin
         next_st.sec_cnt = t1rec_pkg::SEC_CNT_RESET;
         case (st.phase)
            t1rec_pkg::PH_FIRST:  next_st.phase = t1rec_pkg::PH_SECOND;
            t1rec_pkg::PH_SECOND: next_st.phase = t1rec_pkg::PH_LONG;
            t1rec_pkg::PH_LONG:   next_st.phase = t1rec_pkg::PH_FIRST;
            default:              next_st.phase = t1rec_pkg::PH_FIRST;
         endcase
         next_st.snap_line = line_acc;
         next_st.snap_path = path_acc;
         next_st.snap_sync = sync_acc;
      end else begin
         next_st.sec_cnt = st.sec_cnt + t1rec_pkg::SEC_CNT_STEP;
      end
      if (line_bit_strobe) begin
         if (!line_bit_zero) begin
            next_st.zero_run = 5'h00;
         end else if (st.zero_run < zero_target) begin
            next_st.zero_run = st.zero_run + 5'h01;
         end
      end
      if (reg_rd) begin
         case (reg_addr)
            t1rec_pkg::ADDR_LINE_HIGH: begin
               next_st.rdata = st.snap_line[15:8];
            end
            t1rec_pkg::ADDR_LINE_LOW: begin
               next_st.rdata = st.snap_line[7:0];
            end
            t1rec_pkg::ADDR_NIBBLES: begin
               next_st.rdata = {st.snap_sync[11:8], st.snap_path[11:8]};
            end
            t1rec_pkg::ADDR_PATH_LOW: begin
               next_st.rdata = st.snap_path[7:0];
            end
            t1rec_pkg::ADDR_SYNC_LOW: begin
               next_st.rdata = st.snap_sync[7:0];
            end
            default: begin
               next_st.rdata = t1rec_pkg::READ_UNMAPPED;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rdata;
   assign reg_rvalid = st.rvalid;
   assign one_second_flag = st.sec_flag;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   property p_snapshot;
      boundary |=> st.snap_line == $past(line_acc) &&
                   st.snap_path == $past(path_acc) &&
                   st.snap_sync == $past(sync_acc) && one_second_flag;
   endproperty
   a_snapshot: assert property (p_snapshot) else $error("no capture");
   property p_hold;
      !boundary |=> $stable(st.snap_line) && $stable(st.snap_path) &&
                    $stable(st.snap_sync) && !one_second_flag;
   endproperty
   a_hold: assert property (p_hold) else $error("snapshot moved");
   property p_read_line;
      reg_rd && reg_addr == t1rec_pkg::ADDR_LINE_HIGH |=>
         reg_rvalid && reg_rdata == $past(st.snap_line[15:8]);
   endproperty
   a_read_line: assert property (p_read_line) else $error("line byte");
   property p_read_nibbles;
      reg_rd && reg_addr == t1rec_pkg::ADDR_NIBBLES |=>
         reg_rdata == {$past(st.snap_sync[11:8]), $past(st.snap_path[11:8])};
   endproperty
   a_read_nibbles: assert property (p_read_nibbles)
      else $error("shared nibble register wrong");
   property p_read_sync;
      reg_rd && reg_addr == t1rec_pkg::ADDR_SYNC_LOW |=>
         reg_rdata == $past(st.snap_sync[7:0]);
   endproperty
   a_read_sync: assert property (p_read_sync) else $error("sync byte");
   property p_line_in_loss;
      receive_sync_lost && bipolar_violation && !b8zs_code_word &&
      !boundary && line_acc != 16'hffff |=> line_acc == $past(line_acc) + 1'b1;
   endproperty
   a_line_in_loss: assert property (p_line_in_loss)
      else $error("line count missed violation");
   property p_b8zs;
      receive_b8zs_enable && b8zs_code_word && !zero_hit |-> !line_event;
   endproperty
   a_b8zs: assert property (p_b8zs) else $error("code word counted");
   property p_path_freeze;
      receive_sync_lost && !boundary |=> path_acc == $past(path_acc);
   endproperty
   a_path_freeze: assert property (p_path_freeze)
      else $error("path count moved in sync loss");
   property p_path_esf;
      receive_esf_select && !receive_sync_lost |-> path_event == crc6_error;
   endproperty
   a_path_esf: assert property (p_path_esf) else $error("esf path");
   property p_path_d4;
      !receive_esf_select && !receive_sync_lost |->
         path_event == (ft_error || (count_fs_errors_enable && fs_error));
   endproperty
   a_path_d4: assert property (p_path_d4) else $error("d4 path");
   property p_sync_mos;
      out_of_sync_count_select |->
         sync_event == (multiframe_boundary && receive_sync_lost);
   endproperty
   a_sync_mos: assert property (p_sync_mos) else $error("sync event");
   property p_sync_fbit;
      !out_of_sync_count_select && receive_sync_lost |-> !sync_event;
   endproperty
   a_sync_fbit: assert property (p_sync_fbit)
      else $error("framing event counted in sync loss");
   property p_long_wrap;
      boundary && st.phase == t1rec_pkg::PH_LONG |=>
         st.phase == t1rec_pkg::PH_FIRST && st.sec_cnt == 32'h0;
   endproperty
   a_long_wrap: assert property (p_long_wrap) else $error("pattern");
   property p_short_len;
      boundary && st.phase != t1rec_pkg::PH_LONG |->
         st.sec_cnt == 32'(SHORT_CYCLES) - 32'h1;
   endproperty
   a_short_len: assert property (p_short_len) else $error("interval");
   property p_zero_once;
      zero_hit |=> !zero_hit;
   endproperty
   a_zero_once: assert property (p_zero_once) else $error("run twice");
   c_boundary: cover property (boundary ##1 one_second_flag);
   c_read: cover property (reg_rd && reg_addr == t1rec_pkg::ADDR_NIBBLES);
   c_zero: cover property (zero_hit && receive_b8zs_enable);
   c_mos: cover property (sync_event && out_of_sync_count_select);
endmodule
`default_nettype wire

/* File: testbench/t1rec_framer_model.sv */
`default_nettype none
module t1rec_framer_model (
   // Clock
   input  wire logic core_clk,
   // Line decoder events
   output var logic  bipolar_violation,
   output var logic  b8zs_code_word,
   output var logic  line_bit_strobe,
   output var logic  line_bit_zero,
   // Framer events
   output var logic  crc6_error,
   output var logic  ft_error,
   output var logic  fs_error,
   output var logic  fps_error,
   output var logic  multiframe_boundary,
   output var logic  receive_sync_lost
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [6:0] ev       = 7'h00;
   logic       bit_on   = 1'b0;
   logic       bit_zero = 1'b0;
   logic       lost     = 1'b0;
   assign {multiframe_boundary, fps_error, fs_error, ft_error} = ev[6:3];
   assign {crc6_error, b8zs_code_word, bipolar_violation} = ev[2:0];
   assign line_bit_strobe = bit_on;
   assign line_bit_zero = bit_zero;
   assign receive_sync_lost = lost;
   // Hold an event set high for n cycles
   task automatic hold(input logic [6:0] m, input int n);
      @(negedge core_clk);
      ev = m;
      repeat (n) @(negedge core_clk);
      ev = 7'h00;
   endtask
   // Send n zero bits, then one bit
   task automatic zeros(input int n);
      @(negedge core_clk);
      bit_on = 1'b1;
      bit_zero = 1'b1;
      repeat (n) @(negedge core_clk);
      bit_zero = 1'b0;
      @(negedge core_clk);
      bit_on = 1'b0;
   endtask
   task automatic set_lost(input logic v);
      @(negedge core_clk);
      lost = v;
   endtask
endmodule
`default_nettype wire

/* File: testbench/test_t1rec_error_counters.sv */
`default_nettype none
module test_t1rec_error_counters;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int SHORT = 4200;
   localparam int LONG  = 4206;
   logic       core_clk = 1'b0;
   logic       rst = 1'b1;
   logic       b8zs, esf, xz, fsen, sel;
   logic       rd;
   logic [7:0] addr;
   logic [7:0] rdata;
   logic       rvalid, flag;
   logic       bpv, cw, crc, ft, fs, fps, mfb, strobe, zbit, lost;
   int         err_total = 0;
   int         check_count = 0;

   t1rec_framer_model fr (.core_clk(core_clk), .bipolar_violation(bpv),
      .b8zs_code_word(cw), .line_bit_strobe(strobe), .line_bit_zero(zbit),
      .crc6_error(crc), .ft_error(ft), .fs_error(fs), .fps_error(fps),
      .multiframe_boundary(mfb), .receive_sync_lost(lost));

   t1rec_error_counters #(.SHORT_CYCLES(SHORT), .LONG_CYCLES(LONG)) uut (
      .core_clk(core_clk), .rst(rst), .receive_b8zs_enable(b8zs),
      .receive_esf_select(esf), .count_excess_zeros_enable(xz),
      .count_fs_errors_enable(fsen), .out_of_sync_count_select(sel),
      .line_bit_strobe(strobe), .line_bit_zero(zbit),
      .bipolar_violation(bpv), .b8zs_code_word(cw),
      .receive_sync_lost(lost), .crc6_error(crc), .ft_error(ft),
      .fs_error(fs), .fps_error(fps), .multiframe_boundary(mfb),
      .reg_rd(rd), .reg_addr(addr), .reg_rdata(rdata),
      .reg_rvalid(rvalid), .one_second_flag(flag));

   initial forever #20 core_clk = ~core_clk;

   task automatic conclude;
      $display("Checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(negedge core_clk);
      rd = 1'b1;
      addr = a;
      @(negedge core_clk);
      rd = 1'b0;
      check("rvalid", {15'h0, rvalid}, 16'h1);
      check($sformatf("reg %h", a), {8'h00, rdata}, {8'h00, exp});
   endtask

   task automatic wait_flag(output int n);
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (flag !== 1'b1 && n < 5000);
      check("second flag", {15'h0, flag}, 16'h1);
   endtask

   task automatic scen_timing;
      int n;
      int g[3] = '{SHORT, LONG, SHORT};
      rd_chk(t1rec_pkg::ADDR_LINE_HIGH, 8'h00);
      rd_chk(t1rec_pkg::ADDR_NIBBLES, 8'h00);
      rd_chk(8'h28, t1rec_pkg::READ_UNMAPPED);
      wait_flag(n);
      for (int i = 0; i < 3; i++) begin
         wait_flag(n);
         check("interval", 16'(n), 16'(g[i]));
      end
   endtask

   task automatic scen_line;
      int n;
      logic [15:0] e;
      fr.set_lost(1'b1);
      wait_flag(n);
      for (int i = 0; i < 4; i++) begin
         xz = i[1];
         b8zs = i[0];
         fr.hold(7'h01, 2);
         fr.hold(7'h03, 1);
         fr.zeros(17);
         e = 16'(2 + (b8zs ? 0 : 1) + xz);
         wait_flag(n);
         rd_chk(t1rec_pkg::ADDR_LINE_HIGH, e[15:8]);
         rd_chk(t1rec_pkg::ADDR_LINE_LOW, e[7:0]);
         rd_chk(t1rec_pkg::ADDR_LINE_LOW, e[7:0]);
      end
      fr.set_lost(1'b0);
   endtask

   task automatic scen_path;
      int n;
      logic [11:0] p, s;
      sel = 1'b0;
      wait_flag(n);
      for (int i = 0; i < 4; i++) begin
         esf = i[1];
         fsen = i[0];
         fr.hold(7'h04, 1);
         fr.hold(7'h08, 2);
         fr.hold(7'h10, 3);
         fr.hold(7'h20, 4);
         fr.set_lost(1'b1);
         fr.hold(7'h3c, 5);
         fr.set_lost(1'b0);
         p = esf ? 12'h001 : (fsen ? 12'h005 : 12'h002);
         s = esf ? 12'h004 : 12'h002;
         wait_flag(n);
         rd_chk(t1rec_pkg::ADDR_NIBBLES, 8'h00);
         rd_chk(t1rec_pkg::ADDR_PATH_LOW, p[7:0]);
         rd_chk(t1rec_pkg::ADDR_SYNC_LOW, s[7:0]);
      end
   endtask

   task automatic scen_mos;
      int n;
      sel = 1'b1;
      esf = 1'b0;
      wait_flag(n);
      fr.hold(7'h40, 2);
      fr.set_lost(1'b1);
      fr.hold(7'h48, 5);
      fr.set_lost(1'b0);
      fr.hold(7'h08, 3);
      wait_flag(n);
      rd_chk(t1rec_pkg::ADDR_SYNC_LOW, 8'h05);
      rd_chk(t1rec_pkg::ADDR_PATH_LOW, 8'h03);
   endtask

   task automatic scen_sat;
      int n;
      sel = 1'b0;
      esf = 1'b1;
      xz = 1'b0;
      b8zs = 1'b0;
      wait_flag(n);
      fr.hold(7'h25, 4100);
      wait_flag(n);
      rd_chk(t1rec_pkg::ADDR_LINE_HIGH, 8'h10);
      rd_chk(t1rec_pkg::ADDR_LINE_LOW, 8'h04);
      rd_chk(t1rec_pkg::ADDR_NIBBLES, 8'hff);
      rd_chk(t1rec_pkg::ADDR_PATH_LOW, 8'hff);
      rd_chk(t1rec_pkg::ADDR_SYNC_LOW, 8'hff);
      wait_flag(n);
      rd_chk(t1rec_pkg::ADDR_PATH_LOW, 8'h00);
   endtask

   initial begin
      b8zs = 1'b0;
      esf = 1'b0;
      xz = 1'b0;
      fsen = 1'b0;
      sel = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      repeat (4) @(negedge core_clk);
      rst = 1'b0;
      scen_timing();
      scen_line();
      scen_path();
      scen_mos();
      scen_sat();
      conclude();
   end

   initial begin
      repeat (100000) @(posedge core_clk);
      err_total++;
      conclude();
   end
endmodule
`default_nettype wire
